// >>> mac_slice_pkg.sv
/*
  Shared constants and carrier types for the instruction-driven multiply-add slice.
  Assumes a single clock domain; the register map is the only bus-visible contract.
*/
package mac_slice_pkg;

  localparam int ACC_W       = 48;
  localparam int A_W         = 18;
  localparam int B_W         = 18;
  localparam int C_W         = 48;
  localparam int SEL_W       = 6;
  localparam int MAX_INSTR   = 64;
  localparam int FEED_SHIFT  = 17;
  localparam int TIER_COUNT  = 6;

  // register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_RES_LO  = 4'h8;
  localparam logic [3:0] OFS_RES_HI  = 4'hC;

  // control register fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CLR_BIT  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    PIPE_AUTO   = 2'h0,
    PIPE_TIER   = 2'h1,
    PIPE_EXPERT = 2'h2
  } pipe_mode_t;

  typedef enum logic [1:0] {
    FAM_MODERN  = 2'h0,
    FAM_PREADD  = 2'h1,
    FAM_OLDER   = 2'h2
  } family_t;

  typedef enum logic [1:0] {
    ZSRC_ZERO   = 2'h0,
    ZSRC_P      = 2'h1,
    ZSRC_P_SHR  = 2'h2,
    ZSRC_C      = 2'h3
  } z_src_t;

  // decoded internal control word: op mode, subtract, function, input mode
  typedef struct packed {
    z_src_t     z_src;
    logic       use_mult;
    logic       subtract;
    logic       carry_in;
    logic       round_mult;
    logic       use_preadd;
    logic [1:0] in_mode;
  } instr_t;

  localparam int INSTR_W = $bits(instr_t);

  // stage enables: a, b, c, sel(3), mult, sel(5), carry(5), p
  typedef struct packed {
    logic a_reg;
    logic b_reg;
    logic c_reg;
    logic sel3_reg;
    logic m_reg;
    logic sel5_reg;
    logic carry5_reg;
    logic p_reg;
  } stage_en_t;

  typedef struct packed {
    logic [A_W-1:0] a;
    logic [B_W-1:0] b;
    logic [C_W-1:0] c;
    logic [SEL_W-1:0] sel;
  } operand_t;

endpackage

// >>> instr_rom.sv
/*
  Read-only instruction table: index selects a stored control word.
  Assumes the table contents are fixed at elaboration through a parameter.
*/
`timescale 1ns/1ps
module instr_rom #(
  parameter int N_INSTR = 4,
  parameter logic [mac_slice_pkg::MAX_INSTR*mac_slice_pkg::INSTR_W-1:0] TABLE = '0
) (
  input  wire logic [mac_slice_pkg::SEL_W-1:0] index_in,
  output mac_slice_pkg::instr_t                instr_out
);
  import mac_slice_pkg::*;

  instr_t rom [MAX_INSTR];

  // entry 0 is the first defined instruction, numbered upward
  generate
    for (genvar i = 0; i < MAX_INSTR; i++) begin : g_rom
      assign rom[i] = (i < N_INSTR) ? instr_t'(TABLE[i*INSTR_W +: INSTR_W]) : instr_t'('0); // RULE3 RULE2
    end
  endgenerate

  // out-of-range indices yield a harmless zero instruction
  assign instr_out = (int'(index_in) < N_INSTR) ? rom[index_in] : instr_t'('0); // RULE1
endmodule

// >>> pipe_config.sv
/*
  Resolves pipeline mode and per-register requests into forced stage enables.
  Assumes all inputs are elaboration constants; output is pure combinational.
*/
`timescale 1ns/1ps
module pipe_config #(
  parameter mac_slice_pkg::pipe_mode_t MODE        = mac_slice_pkg::PIPE_AUTO,
  parameter mac_slice_pkg::family_t    FAMILY      = mac_slice_pkg::FAM_MODERN,
  parameter logic [5:0]                TIERS       = 6'h3F,
  parameter logic [7:0]                EXPERT_REGS = 8'hFF,
  parameter bit                        USES_P      = 1'b1,
  parameter bit                        USES_PREADD = 1'b0,
  parameter bit                        USES_ROUND  = 1'b0
) (
  output mac_slice_pkg::stage_en_t stage_out
);
  import mac_slice_pkg::*;

  stage_en_t tiered;
  stage_en_t expert;
  logic [5:0] t;

  always_comb begin
    t = TIERS;
    if (USES_P) begin
      t[5] = 1'b1; // RULE10
    end
    if (FAMILY == FAM_PREADD && USES_PREADD && t[4]) begin
      t[2] = 1'b1; // RULE11
    end
    // a tier enables every path at that stage
    tiered.a_reg      = t[0]; // RULE9
    tiered.b_reg      = t[0];
    tiered.c_reg      = t[1];
    tiered.sel3_reg   = t[2];
    tiered.m_reg      = t[3];
    tiered.sel5_reg   = t[4];
    tiered.carry5_reg = t[4];
    tiered.p_reg      = t[5];
  end

  always_comb begin
    expert = stage_en_t'(EXPERT_REGS);
    if (USES_P) begin
      expert.p_reg = 1'b1; // RULE12
    end
    if (FAMILY == FAM_PREADD) begin
      expert.carry5_reg = expert.sel5_reg; // RULE13
      if (expert.sel5_reg && USES_PREADD) begin
        expert.sel3_reg = 1'b1; // RULE14
      end
    end
    if (FAMILY == FAM_OLDER && USES_ROUND) begin
      expert.carry5_reg = 1'b1; // RULE15
    end
  end

  always_comb begin
    case (MODE) // RULE8
      PIPE_TIER:   stage_out = tiered;
      PIPE_EXPERT: stage_out = expert;
      PIPE_AUTO:   stage_out = stage_en_t'(8'hFF);
      default:     stage_out = stage_en_t'(8'hFF);
    endcase
  end
endmodule

// >>> mac_slice.sv
/*
  Instruction-ROM multiply-add slice with configurable pipeline and cascade outputs.
  Assumes operands and select come from fabric logic on clk_in; an Avalon-MM
  master reaches the control/status registers. Any operand muxing is external.
*/
// The register offsets and the Avalon-MM register port were decided locally.
// Summary of operation
// RULE1: one to sixty-four instructions, each decoded into full control word.
// RULE2: read-only table; select input chooses the active instruction.
// RULE3: instructions numbered from zero in order of definition.
// RULE4: mode, subtract, function, input-mode come only from the selected instruction.
// RULE5: one shared enable and one shared synchronous clear drive all registers.
// RULE6: full precision result is 48 bits, whole accumulator.
// RULE7: narrower result keeps top bits, drops low bits, no rounding.
// RULE8: pipeline mode is automatic, per-tier or per-register.
// RULE9: an enabled tier registers every input path at that stage.
// RULE10: previous-result use forces tier six.
// RULE11: pre-adder family: tier five with pre-adder forces tier three.
// RULE12: per-register mode forces result register when result fed back.
// RULE13: pre-adder family: stage-five carry register follows stage-five select register.
// RULE14: pre-adder family: stage-five select plus pre-adder forces stage-three select.
// RULE15: older family: rounding forces stage-five carry register.
// RULE16: optional cascade outputs for A, B, carry and result.
// RULE17: driving logic muxes alternative operands externally.
// RULE18: wide signed multiply feeds 18-bit low/high halves in sequence.
// RULE19: selects 0..3 give A*B, A*B+P>>17, A*B+P, A*B+P>>17.
// RULE20: migrated designs keep the same pipeline selections.
// RULE21: enable low holds every enabled pipeline register.
// RULE22: synchronous clear zeroes every enabled register at next edge.
`timescale 1ns/1ps
module mac_slice #(
  parameter int                        N_INSTR     = 4,
  parameter logic [mac_slice_pkg::MAX_INSTR*mac_slice_pkg::INSTR_W-1:0] TABLE = '0,
  parameter int                        RESULT_W    = 48,
  parameter mac_slice_pkg::pipe_mode_t PIPE_MODE   = mac_slice_pkg::PIPE_AUTO,
  parameter mac_slice_pkg::family_t    FAMILY      = mac_slice_pkg::FAM_MODERN,
  parameter logic [5:0]                TIERS       = 6'h3F,
  parameter logic [7:0]                EXPERT_REGS = 8'hFF,
  parameter bit                        USES_P      = 1'b1,
  parameter bit                        USES_PREADD = 1'b0,
  parameter bit                        USES_ROUND  = 1'b0,
  parameter bit                        USE_A_OPERAND_CASCADE_OUT   = 1'b1,
  parameter bit                        USE_BCOUT   = 1'b1,
  parameter bit                        USE_CARRYCO = 1'b1,
  parameter bit                        USE_PCOUT   = 1'b1
) (
  input  wire logic                            clk_in,
  input  wire logic                            rst_b_in,
  input  wire logic                            enable_in,
  input  wire logic                            shared_sync_clear_in,
  input  wire mac_slice_pkg::operand_t         operand_in,
  input  wire logic [3:0]                      avs_address_in,
  input  wire logic                            avs_read_in,
  input  wire logic                            avs_write_in,
  input  wire logic [31:0]                     avs_writedata_in,
  input  wire logic [3:0]                      avs_byteenable_in,
  output logic [31:0]                          avs_readdata_out,
  output logic                                 avs_waitrequest_out,
  output logic [RESULT_W-1:0]                  result_out,
  output logic [mac_slice_pkg::A_W-1:0]        a_operand_cascade_out,
  output logic [mac_slice_pkg::B_W-1:0]        b_operand_cascade_out,
  output logic                                 carry_cascade_out,
  output logic [mac_slice_pkg::ACC_W-1:0]      result_cascade_out
);
  import mac_slice_pkg::*;

  typedef struct packed {
    logic [A_W-1:0]   a;
    logic [B_W-1:0]   b;
    logic [C_W-1:0]   c;
    logic [SEL_W-1:0] sel3;
    logic [SEL_W-1:0] sel5;
    logic [A_W+B_W-1:0] m;
    logic [ACC_W-1:0] c5;
    logic             carry5;
    logic [ACC_W-1:0] p;
    logic             p_carry;
    logic [1:0]       ctrl;
    logic             bus_ack;
    logic [31:0]      rdata;
  } state_t;

  state_t     r;
  state_t     next_r;
  stage_en_t  st;
  instr_t     ins;
  instr_t     ins3;
  logic       en_eff;
  logic       clr_eff;
  logic [A_W-1:0]   a_s;
  logic [B_W-1:0]   b_s;
  logic [C_W-1:0]   c_s;
  logic [SEL_W-1:0] sel_s3;
  logic [SEL_W-1:0] sel_s5;
  logic [A_W+B_W-1:0] mul_s;
  logic [ACC_W-1:0] prod_ext;
  logic [ACC_W-1:0] z_val;
  logic [ACC_W-1:0] sum;
  logic [ACC_W:0]   sum_full;
  logic             carry_s;
  logic             bus_req;

  pipe_config #(
    .MODE        (PIPE_MODE),
    .FAMILY      (FAMILY),
    .TIERS       (TIERS),
    .EXPERT_REGS (EXPERT_REGS),
    .USES_P      (USES_P),
    .USES_PREADD (USES_PREADD),
    .USES_ROUND  (USES_ROUND)
  ) u_pipe (
    .stage_out (st)
  );

  instr_rom #(
    .N_INSTR (N_INSTR),
    .TABLE   (TABLE)
  ) u_rom (
    .index_in  (sel_s5),
    .instr_out (ins)
  );

  // carry register loads with sel5, so it must decode the select entering that stage
  instr_rom #(
    .N_INSTR (N_INSTR),
    .TABLE   (TABLE)
  ) u_rom3 (
    .index_in  (sel_s3),
    .instr_out (ins3)
  );

  // pins and bus bits combine; either source may stall or clear the slice
  assign en_eff  = enable_in & r.ctrl[CTRL_EN_BIT]; // RULE5
  assign clr_eff = shared_sync_clear_in | r.ctrl[CTRL_CLR_BIT]; // RULE5

  // each stage either registered or bypassed per the resolved enables
  always_comb begin
    a_s     = st.a_reg ? r.a : operand_in.a; // RULE9
    b_s     = st.b_reg ? r.b : operand_in.b;
    c_s     = st.c_reg ? r.c : operand_in.c;
    sel_s3  = st.sel3_reg ? r.sel3 : operand_in.sel;
    sel_s5  = st.sel5_reg ? r.sel5 : sel_s3;
  end

  // signed multiply of the two input halves; low halves arrive with a zero sign bit
  always_comb begin
    mul_s    = st.m_reg ? r.m : (A_W+B_W)'($signed(a_s) * $signed(b_s));
    prod_ext = ACC_W'($signed(mul_s));
  end

  // all adder controls from the selected instruction only
  always_comb begin
    case (ins.z_src) // RULE4
      ZSRC_ZERO:  z_val = '0;
      ZSRC_P:     z_val = r.p; // RULE19
      ZSRC_P_SHR: z_val = ACC_W'($signed(r.p) >>> FEED_SHIFT); // RULE19 RULE18
      ZSRC_C:     z_val = c_s;
      default:    z_val = '0;
    endcase
    carry_s = st.carry5_reg ? r.carry5 : (ins.carry_in | ins.round_mult);
    if (ins.subtract) begin
      sum_full = {1'b0, z_val} - {1'b0, (ins.use_mult ? prod_ext : {ACC_W{1'b0}})} - {{ACC_W{1'b0}}, carry_s};
    end else begin
      sum_full = {1'b0, z_val} + {1'b0, (ins.use_mult ? prod_ext : {ACC_W{1'b0}})} + {{ACC_W{1'b0}}, carry_s};
    end
    sum = sum_full[ACC_W-1:0];
  end

  assign bus_req = (avs_read_in | avs_write_in) & ~r.bus_ack;

  always_comb begin
    next_r = r;
    next_r.bus_ack = bus_req;
    // pipeline registers: clear beats hold, hold beats load
    if (clr_eff) begin
      next_r.a = '0; // RULE22
      next_r.b = '0;
      next_r.c = '0;
      next_r.sel3 = '0;
      next_r.sel5 = '0;
      next_r.m = '0;
      next_r.carry5 = 1'b0;
      next_r.p = '0;
      next_r.p_carry = 1'b0;
    end else if (en_eff) begin // RULE21
      next_r.a = operand_in.a;
      next_r.b = operand_in.b;
      next_r.c = operand_in.c;
      next_r.sel3 = operand_in.sel;
      next_r.sel5 = sel_s3;
      next_r.m = (A_W+B_W)'($signed(a_s) * $signed(b_s));
      next_r.carry5 = ins3.carry_in | ins3.round_mult; // RULE13
      next_r.p = sum; // RULE6
      next_r.p_carry = sum_full[ACC_W];
    end
    // one wait state: request taken on the second edge
    if (bus_req) begin
      next_r.rdata = UNMAPPED_READ;
      case (avs_address_in)
        OFS_CTRL:   next_r.rdata = {30'h0, r.ctrl};
        OFS_STATUS: next_r.rdata = {16'h0, st, 2'h0, sel_s5};
        OFS_RES_LO: next_r.rdata = r.p[31:0];
        OFS_RES_HI: next_r.rdata = {16'h0, r.p[ACC_W-1:32]};
        default:    next_r.rdata = UNMAPPED_READ;
      endcase
    end
    // write lands on the accepting edge, when waitrequest is already low
    if (avs_write_in && r.bus_ack && avs_address_in == OFS_CTRL && avs_byteenable_in[0]) begin
      next_r.ctrl = avs_writedata_in[1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      r      <= '0;
      r.ctrl <= CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~r.bus_ack;
  assign avs_readdata_out    = r.rdata;

  // result taps the top bits; low bits are simply dropped
  generate
    if (RESULT_W >= ACC_W) begin : g_full
      assign result_out = RESULT_W'(st.p_reg ? r.p : sum); // RULE6
    end else begin : g_trunc
      logic [ACC_W-1:0] p_sel;
      assign p_sel = st.p_reg ? r.p : sum;
      assign result_out = p_sel[ACC_W-1 -: RESULT_W]; // RULE7
    end
  endgenerate

  // unused cascades tie to zero so downstream slices see a clean input
  assign a_operand_cascade_out = USE_A_OPERAND_CASCADE_OUT   ? a_s : '0; // RULE16
  assign b_operand_cascade_out = USE_BCOUT   ? b_s : '0; // RULE16
  assign carry_cascade_out     = USE_CARRYCO ? r.p_carry : 1'b0; // RULE16
  assign result_cascade_out    = USE_PCOUT   ? r.p : '0; // RULE16
endmodule

// >>> mac_slice_monitor.sv
/*
  Port-level checker for mac_slice: clear, hold and truncation relations.
  Assumes it is bound to every mac_slice instance; single clock clk_in.
*/
`timescale 1ns/1ps
module mac_slice_monitor #(
  parameter int RESULT_W = 48
) (
  input wire logic                           clk_in,
  input wire logic                           rst_b_in,
  input wire logic                           enable_in,
  input wire logic                           shared_sync_clear_in,
  input wire logic [RESULT_W-1:0]            result_out,
  input wire logic [mac_slice_pkg::A_W-1:0]  a_operand_cascade_out,
  input wire logic [mac_slice_pkg::B_W-1:0]  b_operand_cascade_out,
  input wire logic                           carry_cascade_out,
  input wire logic [mac_slice_pkg::ACC_W-1:0] result_cascade_out
);
  import mac_slice_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_trunc; result_out == result_cascade_out[ACC_W-1 -: RESULT_W]; endproperty
  a_trunc: assert property (p_trunc) else $error("result_out is not the top of the accumulator");
  property p_clear_p; shared_sync_clear_in |=> result_cascade_out == '0 && !carry_cascade_out; endproperty
  a_clear_p: assert property (p_clear_p) else $error("clear left accumulator or carry set");
  property p_clear_ab; shared_sync_clear_in |=> a_operand_cascade_out == '0 && b_operand_cascade_out == '0; endproperty
  a_clear_ab: assert property (p_clear_ab) else $error("clear left operand cascade set");
  property p_hold_p; !enable_in && !shared_sync_clear_in |=> $stable(result_cascade_out); endproperty
  a_hold_p: assert property (p_hold_p) else $error("accumulator moved while disabled");
  property p_hold_carry; (!enable_in && !shared_sync_clear_in) [*2] |=> $stable(carry_cascade_out); endproperty
  a_hold_carry: assert property (p_hold_carry) else $error("carry moved while disabled");
  property p_ab_cause;
    $changed(a_operand_cascade_out) || $changed(b_operand_cascade_out) |-> $past(enable_in || shared_sync_clear_in);
  endproperty
  a_ab_cause: assert property (p_ab_cause) else $error("operand cascade moved without enable");
  property p_res_cause; $changed(result_out) |-> $past(enable_in) || $past(shared_sync_clear_in); endproperty
  a_res_cause: assert property (p_res_cause) else $error("result moved without enable or clear");
  property p_clear_run; shared_sync_clear_in [*2] |-> result_out == '0; endproperty
  a_clear_run: assert property (p_clear_run) else $error("result nonzero during clear");
endmodule

// >>> fabric_feed.sv
/*
  Fabric-side operand mux for the wide multiply: splits 35-bit operands.
  Assumes the bench drives select and operands on the slice clock.
*/
`timescale 1ns/1ps
module fabric_feed (
  input  wire logic [5:0]         sel_in,
  input  wire logic [34:0]        a_in,
  input  wire logic [34:0]        b_in,
  input  wire logic [47:0]        c_in,
  output mac_slice_pkg::operand_t operand_out
);
  import mac_slice_pkg::*;
  // slice has no operand mux, so select bit1 picks A half, bit0 B half
  always_comb begin
    operand_out.sel = sel_in;
    operand_out.a   = sel_in[1] ? a_in[34:17] : {1'b0, a_in[16:0]};
    operand_out.b   = sel_in[0] ? b_in[34:17] : {1'b0, b_in[16:0]};
    operand_out.c   = c_in;
  end
endmodule

// >>> mac_slice_tb.sv
/*
  Self-checking bench for mac_slice: wide multiply, subtract, refusal, hold, clears.
  Assumes fabric_feed as operand source and the Avalon slave timing of the note.
*/
`timescale 1ns/1ps
module mac_slice_tb;
  import mac_slice_pkg::*;
  localparam int RW = 40;
  // entry 5 lies past N_INSTR, so a select of 5 must not reach it
  localparam logic [MAX_INSTR*INSTR_W-1:0] TBL = {522'h0, 9'h0C0, 9'h1E0, 9'h140, 9'h0C0, 9'h140, 9'h040};
  logic clk_in = 1'b0, rst_b_in = 1'b0, enable_in = 1'b1, shared_sync_clear_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, carry_cascade_out;
  logic [5:0] fsel = 6'h0;
  logic [34:0] fa = 35'h0, fb = 35'h0;
  logic [47:0] fc = 48'h0, result_cascade_out;
  logic [RW-1:0] result_out;
  logic [A_W-1:0] a_operand_cascade_out;
  logic [B_W-1:0] b_operand_cascade_out;
  operand_t operand_in;
  int fails = 0, n_tests = 0;
  always #50 clk_in = ~clk_in;
  fabric_feed FEED (.sel_in(fsel), .a_in(fa), .b_in(fb), .c_in(fc), .operand_out(operand_in));
  mac_slice #(.N_INSTR(5), .TABLE(TBL), .RESULT_W(RW)) DUT (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
    .shared_sync_clear_in(shared_sync_clear_in), .operand_in(operand_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .result_out(result_out), .a_operand_cascade_out(a_operand_cascade_out),
    .b_operand_cascade_out(b_operand_cascade_out), .carry_cascade_out(carry_cascade_out),
    .result_cascade_out(result_cascade_out));
  task stop_test;
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic wr, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in <= ad;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // only the watchdog ends a stuck wait
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task chk_rd(input string nm, input logic [3:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    cmp(nm, {16'h0, e}, {16'h0, q});
  endtask
  task chk_p(input logic [47:0] e);
    cmp("result_cascade_out", e, result_cascade_out);
    cmp("result_out", {8'h0, e[47:8]}, {8'h0, result_out});
  endtask
  // one operand per edge; enable raised with it
  task op(input logic [5:0] s, input logic [34:0] a, input logic [34:0] b, input logic [47:0] c);
    @(posedge clk_in);
    enable_in <= 1'b1;
    fsel <= s;
    fa <= a;
    fb <= b;
    fc <= c;
  endtask
  // three register stages to the result, then freeze the pipe
  task drain;
    repeat (3) @(posedge clk_in);
    enable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task t_regs;
    chk_rd("ctrl", OFS_CTRL, 32'h1);
    chk_rd("unmapped", 4'h2, 32'h0);
    chk_rd("status", OFS_STATUS, 32'h0000_FF00);
  endtask
  task t_wide(input logic [34:0] a, input logic [34:0] b, input logic ec);
    logic signed [69:0] pr;
    logic [47:0] e;
    for (int s = 0; s < 4; s++) op(6'(s), a, b, 48'h0);
    drain;
    pr = $signed(a) * $signed(b);
    e = 48'(pr >>> 34);
    chk_p(e);
    cmp("carry_cascade_out", {47'h0, ec}, {47'h0, carry_cascade_out});
    chk_rd("res_lo", OFS_RES_LO, e[31:0]);
    chk_rd("res_hi", OFS_RES_HI, {16'h0, e[47:32]});
  endtask
  task t_sub(input logic [34:0] a, input logic [34:0] b, input logic [47:0] c);
    logic [47:0] e;
    logic [31:0] q;
    op(6'h04, a, b, c);
    drain;
    e = c - 48'(a[16:0]) * 48'(b[16:0]);
    chk_p(e);
    @(posedge clk_in);
    fsel <= 6'h00;
    fa <= ~a;
    repeat (4) @(posedge clk_in);
    chk_p(e);
    bus(1'b1, OFS_RES_LO, 32'hFFFF_FFFF, q);
    chk_rd("res_lo", OFS_RES_LO, e[31:0]);
    // accumulate so a missed clear shows
    op(6'h02, a, b, c);
    bus(1'b1, OFS_CTRL, 32'h3, q);
    repeat (3) @(posedge clk_in);
    chk_p(48'h0);
    bus(1'b1, OFS_CTRL, 32'h1, q);
  endtask
  task t_refuse;
    op(6'h05, 35'h1_2345_6789, 35'h0_0000_0007, 48'h0);
    drain;
    chk_p(48'h0);
  endtask
  task t_pin_clear;
    @(posedge clk_in);
    shared_sync_clear_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    shared_sync_clear_in <= 1'b0;
    chk_p(48'h0);
    cmp("a_cascade", 48'h0, {30'h0, a_operand_cascade_out});
    cmp("b_cascade", 48'h0, {30'h0, b_operand_cascade_out});
    cmp("carry_cascade_out", 48'h0, {47'h0, carry_cascade_out});
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs;
    t_wide(35'h1_2345_6789, 35'h0_9876_5432, 1'b0);
    t_wide(35'h7_FFFF_FFFB, 35'h3_FFFF_FFFF, 1'b0);
    t_refuse;
    t_sub(35'h0_0001_FFFF, 35'h0_0000_0003, 48'h1234_5678_9ABC);
    t_wide(35'h4_0000_0001, 35'h4_0000_0000, 1'b1);
    t_pin_clear;
    stop_test;
  end
endmodule

bind mac_slice mac_slice_monitor #(.RESULT_W(RESULT_W)) u_monitor (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in),
  .shared_sync_clear_in(shared_sync_clear_in), .result_out(result_out),
  .a_operand_cascade_out(a_operand_cascade_out), .b_operand_cascade_out(b_operand_cascade_out),
  .carry_cascade_out(carry_cascade_out), .result_cascade_out(result_cascade_out));
